/* File: delay_timer_pkg.sv */
`default_nettype none
package delay_timer_pkg;

    // Wishbone register byte offsets.
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] CONST_OFFSET = 4'h4;
    localparam logic [3:0] STATUS_OFFSET = 4'h8;
    localparam logic [3:0] ELAPSED_OFFSET = 4'hc;
    localparam int ADDR_W = 4;

    // Control register field positions.
    localparam int RUN_GATE_BIT = 0;
    localparam int CLEAR_BIT = 1;
    localparam int ON_TRIG_BIT = 2;
    localparam int OFF_TRIG_BIT = 3;
    localparam int LIMIT_TRIG_BIT = 4;
    localparam int CTRL_W = 5;

    // Status register field positions.
    localparam int STATE_BIT = 0;
    localparam int MODE_LSB = 1;
    localparam int PHASE_LSB = 3;

    // Reset values.
    localparam logic [4:0] CTRL_RESET = 5'h01;
    localparam logic [31:0] CONST_RESET = 32'h0000_0000;
    localparam logic [31:0] ELAPSED_RESET = 32'h0000_0000;

    // Timing: one elapsed-time unit is one millisecond.
    localparam int CLK_HZ = 200_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    typedef enum logic [1:0] {
        MODE_NONE = 2'b00,
        MODE_ON = 2'b01,
        MODE_OFF = 2'b11,
        MODE_LIMIT = 2'b10
    } mode_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_TIMING = 2'b01,
        PH_HOLD = 2'b11,
        PH_DONE = 2'b10
    } phase_t;

    typedef struct packed {
        logic pulse_limit_trigger;
        logic delayed_off_trigger;
        logic delayed_on_trigger;
        logic clear_input;
        logic run_gate;
    } ctrl_t;

endpackage
`default_nettype wire

/* File: ms_tick_gen.sv */
`timescale 1ns/100ps
`default_nettype none
module ms_tick_gen
    import delay_timer_pkg::*;
#(
    parameter int DIV = TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    output logic tick
);
    logic [31:0] cnt_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (cnt_q == 32'(DIV - 1)) begin
            cnt_q <= 32'h0000_0000;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: edge_detect.sv */
`timescale 1ns/100ps
`default_nettype none
module edge_detect #(
    parameter int W = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] prev_q;

    // Previous levels start low, so a bit set at reset release counts as a rise.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev_q <= '0;
        end else begin
            prev_q <= level;
        end
    end

    assign rise = level & ~prev_q;
    assign fall = ~level & prev_q;
endmodule
`default_nettype wire

/* File: multi_mode_delay_timer.sv */
// Behaviour
// R1 - On-delay rising trigger starts timing, output low
// R2 - On-delay expiry sets output until trigger falls
// R3 - On-delay elapsed held until next rising trigger
// R4 - On-delay early fall freezes count, output low
// R5 - Clear rising edge zeroes output and elapsed
// R6 - Low run gate pauses counting until high
// R7 - Off-delay rising trigger sets output, no timing
// R8 - Off-delay falling trigger starts timing from zero
// R9 - Off-delay and limit expiry stop, output low
// R10 - Off-delay elapsed held until fresh rising trigger
// R11 - Off-delay early rise retriggers, restarts from zero
// R12 - Limit rising trigger sets output, starts timing
// R13 - Limit early fall stops timing, output low
// R14 - Limit elapsed held; new rise needed restart
// R15 - Controller supplies 32-bit millisecond time constant
// R16 - Start-up leaves output low, elapsed zero
// R17 - Triggering sets run gate high by default
// R18 - Elapsed is 32-bit, one per millisecond tick
// R19 - Last accepted trigger selects mode; others ignored
`timescale 1ns/100ps
`default_nettype none
module multi_mode_delay_timer
    import delay_timer_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic timer_state
);
    ctrl_t ctrl_q;
    logic [31:0] const_q;
    logic [31:0] elapsed_q;
    mode_t mode_q;
    phase_t phase_q;
    logic tick;
    logic [3:0] lv;
    logic [3:0] rise;
    logic [3:0] fall;
    logic bus_req;
    logic wr_ctrl;
    logic wr_const;
    logic clr_rise;
    logic ready_to_arm;
    logic acc_on;
    logic acc_off;
    logic acc_limit;
    logic expired;
    logic count_en;

    function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    ms_tick_gen #(.DIV(TICK_DIV)) u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(tick)
    );

    // Bit 0 clear, 1 on-delay, 2 off-delay, 3 pulse-limit.
    assign lv = {ctrl_q.pulse_limit_trigger, ctrl_q.delayed_off_trigger,
                 ctrl_q.delayed_on_trigger, ctrl_q.clear_input};

    edge_detect #(.W(4)) u_edges (
        .ref_clk(ref_clk),
        .rst(rst),
        .level(lv),
        .rise(rise),
        .fall(fall)
    );

    // Single-cycle classic slave: ack one edge after the request is seen.
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_ctrl = bus_req && wb_we_i && (wb_adr_i == CTRL_OFFSET);
    assign wr_const = bus_req && wb_we_i && (wb_adr_i == CONST_OFFSET);

    assign clr_rise = rise[0];
    // Triggers are only accepted with the gate high and clear low; an armed
    // timer owns the mode, so other triggers cannot steal it mid-sequence.
    assign ready_to_arm = ctrl_q.run_gate && !ctrl_q.clear_input && !clr_rise;
    assign acc_on = ready_to_arm && rise[1] &&
                    (phase_q == PH_IDLE || phase_q == PH_DONE); // R19
    assign acc_off = ready_to_arm && rise[2] &&
                     (phase_q == PH_IDLE || phase_q == PH_DONE ||
                      mode_q == MODE_OFF); // R19
    assign acc_limit = ready_to_arm && rise[3] &&
                       (phase_q == PH_IDLE || phase_q == PH_DONE); // R19
    assign expired = (phase_q == PH_TIMING) && (elapsed_q >= const_q);
    // A stopping fall freezes the count in the very cycle it is seen, even on a tick.
    assign count_en = (phase_q == PH_TIMING) && !expired && tick && ctrl_q.run_gate && // R6
                      !(mode_q == MODE_ON && fall[1]) && // R4
                      !(mode_q == MODE_LIMIT && fall[3]); // R13

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                CTRL_OFFSET: wb_dat_o <= {27'h0, ctrl_q};
                CONST_OFFSET: wb_dat_o <= const_q;
                STATUS_OFFSET: wb_dat_o <= {27'h0, phase_q, mode_q, timer_state};
                ELAPSED_OFFSET: wb_dat_o <= elapsed_q;
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= ctrl_t'(CTRL_RESET);
        end else begin
            if (wr_ctrl && wb_sel_i[0]) begin
                ctrl_q <= ctrl_t'(wb_dat_i[CTRL_W-1:0]);
            end
            // The hardware default wins over a write landing in the same cycle.
            if (acc_on || acc_off || acc_limit) begin
                ctrl_q.run_gate <= 1'b1; // R17
            end
        end
    end

    // Any 32-bit value is legal; zero expires on the first timing cycle.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            const_q <= CONST_RESET;
        end else if (wr_const) begin
            const_q <= merge_lanes(const_q, wb_dat_i, wb_sel_i); // R15
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            elapsed_q <= ELAPSED_RESET; // R16
        end else if (clr_rise) begin
            elapsed_q <= 32'h0000_0000; // R5
        end else if (acc_on || acc_off || acc_limit) begin
            elapsed_q <= 32'h0000_0000; // R1 R11 R12
        end else if (mode_q == MODE_OFF && phase_q == PH_HOLD && fall[2]) begin
            elapsed_q <= 32'h0000_0000; // R8
        end else if (count_en) begin
            elapsed_q <= elapsed_q + 32'h0000_0001; // R18
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_q <= MODE_NONE;
            phase_q <= PH_IDLE;
            timer_state <= 1'b0; // R16
        end else if (clr_rise) begin
            mode_q <= MODE_NONE;
            phase_q <= PH_IDLE;
            timer_state <= 1'b0; // R5
        end else if (acc_on) begin
            mode_q <= MODE_ON;
            phase_q <= PH_TIMING;
            timer_state <= 1'b0; // R1
        end else if (acc_off) begin
            mode_q <= MODE_OFF;
            phase_q <= PH_HOLD;
            timer_state <= 1'b1; // R7 R11
        end else if (acc_limit) begin
            mode_q <= MODE_LIMIT;
            phase_q <= PH_TIMING;
            timer_state <= 1'b1; // R12
        end else begin
            case (mode_q)
                MODE_ON: begin
                    if (phase_q == PH_TIMING && fall[1]) begin
                        phase_q <= PH_DONE; // R4
                    end else if (expired) begin
                        phase_q <= PH_HOLD;
                        timer_state <= 1'b1; // R2
                    end else if (phase_q == PH_HOLD && fall[1]) begin
                        phase_q <= PH_DONE;
                        timer_state <= 1'b0; // R2 R3
                    end
                end
                MODE_OFF: begin
                    if (phase_q == PH_HOLD && fall[2]) begin
                        phase_q <= PH_TIMING; // R8
                    end else if (expired) begin
                        phase_q <= PH_DONE;
                        timer_state <= 1'b0; // R9 R10
                    end
                end
                MODE_LIMIT: begin
                    if (phase_q == PH_TIMING && fall[3]) begin
                        phase_q <= PH_DONE;
                        timer_state <= 1'b0; // R13
                    end else if (expired) begin
                        phase_q <= PH_DONE;
                        timer_state <= 1'b0; // R9 R14
                    end
                end
                default: begin
                    phase_q <= PH_IDLE;
                    timer_state <= 1'b0;
                end
            endcase
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic no_arm;
    assign no_arm = !(acc_on || acc_off || acc_limit) && !clr_rise;

    a_clear_zeroes: assert property (clr_rise |=> !timer_state && elapsed_q == 0) // R5
        else $error("clear edge did not zero the timer");

    a_on_start: assert property (acc_on |=> phase_q == PH_TIMING && elapsed_q == 0 // R1
                                  && !timer_state)
        else $error("on-delay start wrong");

    // A clear seen in the cycle after expiry may legally drop the output one edge later.
    a_on_expiry: assert property (mode_q == MODE_ON && expired && no_arm && !fall[1] // R2
                                   |=> timer_state ##1 (timer_state
                                   || !ctrl_q.delayed_on_trigger || $past(clr_rise)))
        else $error("on-delay expiry did not raise output");

    a_on_held: assert property (mode_q == MODE_ON && phase_q == PH_DONE && no_arm // R3
                                 |=> $stable(elapsed_q) && !timer_state)
        else $error("on-delay elapsed changed after end");

    a_on_early_fall: assert property (mode_q == MODE_ON && phase_q == PH_TIMING && fall[1] // R4
                                       && no_arm |=> phase_q == PH_DONE && !timer_state
                                       && $stable(elapsed_q))
        else $error("on-delay early fall wrong");

    a_gate_pause: assert property (phase_q == PH_TIMING && !ctrl_q.run_gate && no_arm // R6
                                    |=> elapsed_q == $past(elapsed_q))
        else $error("count advanced with gate low");

    a_off_arm: assert property (acc_off |=> timer_state && phase_q == PH_HOLD // R7
                                 && elapsed_q == 0)
        else $error("off-delay arm wrong");

    a_off_fall: assert property (mode_q == MODE_OFF && phase_q == PH_HOLD && fall[2] // R8
                                  && no_arm |=> phase_q == PH_TIMING && elapsed_q == 0
                                  && timer_state)
        else $error("off-delay fall did not start timing");

    a_expire_low: assert property (mode_q != MODE_ON && expired && no_arm // R9
                                    && !(mode_q == MODE_LIMIT && fall[3])
                                    |=> !timer_state && phase_q == PH_DONE)
        else $error("expiry did not drop output");

    a_off_held: assert property (mode_q == MODE_OFF && phase_q == PH_DONE && no_arm // R10
                                  |=> $stable(elapsed_q) && !timer_state)
        else $error("off-delay elapsed changed after end");

    a_limit_start: assert property (acc_limit |=> timer_state && phase_q == PH_TIMING // R12
                                     && elapsed_q == 0)
        else $error("pulse-limit start wrong");

    a_limit_fall: assert property (mode_q == MODE_LIMIT && phase_q == PH_TIMING && fall[3] // R13
                                    && no_arm |=> !timer_state && $stable(elapsed_q))
        else $error("limit early fall wrong");

    a_limit_held: assert property (mode_q == MODE_LIMIT && phase_q == PH_DONE && no_arm // R14
                                    |=> $stable(elapsed_q) && !timer_state)
        else $error("pulse-limit elapsed changed after end");

    a_arm_gate: assert property ((acc_on || acc_off || acc_limit) |=> ctrl_q.run_gate) // R17
        else $error("trigger did not leave the run gate high");

    a_tick_count: assert property (count_en && no_arm // R18
                                    |=> elapsed_q == $past(elapsed_q) + 32'h1)
        else $error("elapsed did not advance on tick");

    c_on_cycle: cover property (mode_q == MODE_ON && phase_q == PH_HOLD);
    c_off_retrig: cover property (mode_q == MODE_OFF && phase_q == PH_TIMING ##1 acc_off);
    c_limit_fall: cover property (mode_q == MODE_LIMIT && phase_q == PH_TIMING && fall[3]);
    c_clear: cover property (phase_q == PH_TIMING && clr_rise);
endmodule
`default_nettype wire

/* File: timer_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module timer_host_model
    import delay_timer_pkg::*;
(
    input wire logic ref_clk,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    output logic wb_cyc_i,
    output logic wb_stb_i,
    output logic wb_we_i,
    output logic [ADDR_W-1:0] wb_adr_i,
    output logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_i
);
    initial begin
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = '0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
    end
    // The request is held until ack, so a slow answer is never cut short; only the
    // bench watchdog ends a wait that never gets an answer.
    task automatic cycle(input logic we, input logic [ADDR_W-1:0] a, input logic [3:0] s,
                         input logic [31:0] wd, output logic [31:0] rd);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= wd;
        do begin
            @(posedge ref_clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: multi_mode_delay_timer_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module multi_mode_delay_timer_tb_top
    import delay_timer_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic cyc, stb, we, ack, state;
    logic [ADDR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    int err_count = 0;
    int comparisons = 0;
    int seed = 24488;
    logic [31:0] held_q[$];

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    timer_host_model timer_host_model_inst (.ref_clk(ref_clk), .wb_ack_o(ack),
        .wb_dat_o(rdat), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat));

    // A 4-cycle tick keeps every time constant short in simulation.
    multi_mode_delay_timer #(.TICK_DIV(4)) multi_mode_delay_timer_inst (.ref_clk(ref_clk),
        .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .timer_state(state));

    function automatic logic [31:0] st(logic s, mode_t m, phase_t p);
        return {27'h0, p, m, s};
    endfunction

    task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d, logic [3:0] s = 4'hf);
        logic [31:0] x;
        timer_host_model_inst.cycle(1'b1, a, s, d, x);
    endtask
    task automatic rd(logic [ADDR_W-1:0] a, output logic [31:0] d);
        timer_host_model_inst.cycle(1'b0, a, 4'hf, 32'h0, d);
    endtask
    task automatic ctl(logic [31:0] d);
        wr(CTRL_OFFSET, d);
    endtask
    task automatic nap(int n = 3);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk_reg(string nm, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pin(logic e);
        comparisons++;
        if (state !== e) begin
            err_count++;
            $display("ERROR timer_state expected %b seen %b", e, state);
        end
    endtask
    task automatic xr(logic [ADDR_W-1:0] a, logic [31:0] e, logic [31:0] m = '1);
        logic [31:0] d;
        rd(a, d);
        chk_reg($sformatf("reg %h", a), e & m, d & m);
    endtask
    task automatic sts(logic [31:0] e, logic [31:0] m = 32'h1f);
        xr(STATUS_OFFSET, e, m);
    endtask
    task automatic el(logic [31:0] e);
        xr(ELAPSED_OFFSET, e);
    endtask
    task automatic wait_st(logic [31:0] e, logic [31:0] m);
        logic [31:0] d;
        int n;
        n = 0;
        do begin
            rd(STATUS_OFFSET, d);
            n++;
        end while ((d & m) !== (e & m) && n < 200);
        chk_reg("status wait", e & m, d & m);
    endtask
    task automatic freeze();
        logic [31:0] d;
        rd(ELAPSED_OFFSET, d);
        held_q.push_back(d);
        nap(30);
    endtask

    task automatic complete_run();
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #200_000;
        err_count++;
        complete_run();
    end

    initial begin
        logic [31:0] c;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        xr(CTRL_OFFSET, 32'h1);
        xr(CONST_OFFSET, 32'h0);
        sts(32'h0);
        el(32'h0);
        wr(ELAPSED_OFFSET, 32'h5);
        wr(4'h2, 32'hffff_ffff);
        xr(4'h2, 32'h0);
        el(32'h0);
        wr(CONST_OFFSET, 32'haabb_ccdd);
        wr(CONST_OFFSET, 32'h1122_3344, 4'h2);
        xr(CONST_OFFSET, 32'haabb_33dd);
        wr(CONST_OFFSET, 32'h6);
        ctl(32'h05);
        nap();
        xr(CTRL_OFFSET, 32'h05);
        sts(st(1'b0, MODE_ON, PH_TIMING));
        wait_st(st(1'b1, MODE_ON, PH_HOLD), 32'h1f);
        chk_pin(1'b1);
        el(32'h6);
        ctl(32'h01);
        nap();
        sts(st(1'b0, MODE_ON, PH_DONE));
        el(32'h6);
        wr(CONST_OFFSET, 32'h28);
        ctl(32'h05);
        nap(20);
        ctl(32'h04);
        nap();
        freeze();
        el(held_q.pop_front());
        sts(st(1'b0, MODE_ON, PH_TIMING));
        ctl(32'h05);
        wait_st(st(1'b1, MODE_ON, PH_HOLD), 32'h1f);
        el(32'h28);
        ctl(32'h01);
        ctl(32'h05);
        nap(20);
        ctl(32'h01);
        nap();
        freeze();
        el(held_q.pop_front());
        sts(32'h0, 32'h1);
        // Clear arrives together with a trigger rise; clear has to win.
        ctl(32'h07);
        nap();
        sts(32'h0);
        el(32'h0);
        ctl(32'h05);
        nap();
        sts(32'h0);
        ctl(32'h01);
        wr(CONST_OFFSET, 32'h14);
        ctl(32'h09);
        nap(30);
        sts(32'h1, 32'h1);
        el(32'h0);
        ctl(32'h01);
        nap(30);
        rd(ELAPSED_OFFSET, c);
        chk_reg("off count", 32'h1, 32'(c > 0 && c < 32'h14));
        ctl(32'h09);
        nap();
        sts(st(1'b1, MODE_OFF, PH_IDLE), 32'h7);
        el(32'h0);
        ctl(32'h01);
        wait_st(32'h0, 32'h1);
        el(32'h14);
        nap(30);
        el(32'h14);
        wr(CONST_OFFSET, 32'hc);
        ctl(32'h11);
        nap();
        sts(st(1'b1, MODE_LIMIT, PH_TIMING));
        ctl(32'h15);
        nap();
        sts(st(1'b1, MODE_LIMIT, PH_IDLE), 32'h7);
        wait_st(st(1'b0, MODE_LIMIT, PH_IDLE), 32'h7);
        el(32'hc);
        ctl(32'h01);
        wr(CONST_OFFSET, 32'h3c);
        ctl(32'h11);
        nap(20);
        ctl(32'h01);
        nap();
        sts(32'h0, 32'h1);
        freeze();
        el(held_q.pop_front());
        ctl(32'h11);
        nap();
        sts(32'h1, 32'h1);
        ctl(32'h13);
        nap();
        sts(32'h0);
        el(32'h0);
        ctl(32'h11);
        nap(30);
        sts(32'h0);
        chk_pin(1'b0);
        for (int i = 0; i < 4; i++) begin
            c = 32'($random(seed)) & 32'h7;
            ctl(32'h01);
            wr(CONST_OFFSET, c);
            ctl(32'h05);
            wait_st(st(1'b1, MODE_ON, PH_HOLD), 32'h1f);
            el(c);
        end
        complete_run();
    end
endmodule
`default_nettype wire
